// ---- rtl/ssw_capture.sv ----
`timescale 1ns/1ns
`include "ssw_defs.svh"
module ssw_capture #(
    parameter int SW = 16,                 // Sample width.
    parameter int NS = `SSW_REC_SAMPLES     // Record depth in samples.
) (
    // Clock and reset.
    input  wire logic                      i_clk_sys,
    input  wire logic                      i_rst_n,
    // Configuration, static while enabled.
    input  wire ssw_pkg::ssw_cfg_s         i_cfg,
    input  wire logic                      i_manual_trig,
    // Sample stream and per-cycle RMS magnitude, same clock domain.
    input  wire logic                      i_smp_valid,
    input  wire logic [SW-1:0]             i_smp_data,
    input  wire logic                      i_rms_valid,
    input  wire logic [20:0]               i_rms_volts,
    // Record readout for the export engine.
    input  wire logic                      i_rd_en,
    input  wire logic [$clog2(NS)-1:0]     i_rd_idx,
    output logic      [SW-1:0]             o_rd_data,
    output logic                           o_rec_done,
    input  wire logic                      i_rec_ack,
    // Status.
    output ssw_pkg::ssw_stat_s             o_stat
);
    import ssw_pkg::*;

    localparam int AW = $clog2(NS);

    // ======================================================================
    // Configuration checks and derived counts.
    // ======================================================================
    // Capacity in cycles for the chosen rate.
    function automatic logic [6:0] cap_of(input logic [1:0] rate);
        case (rate)
            `SSW_RATE_128: cap_of = `SSW_CAP_128;
            `SSW_RATE_64:  cap_of = `SSW_CAP_64;
            `SSW_RATE_32:  cap_of = `SSW_CAP_32;
            default:       cap_of = `SSW_CAP_16;
        endcase
    endfunction

    // Samples in one power cycle; log2 form used as a shift.
    function automatic logic [2:0] spc_shift(input logic [1:0] rate);
        spc_shift = 3'h7 - {1'b0, rate};
    endfunction

    logic [6:0]  cap;            // Cycles the record can hold.
    logic [6:0]  post_cyc;       // Derived post-trigger cycle count.
    logic        pre_ok;         // Pre-cycle count within range.
    logic        thr_ok;         // Voltage settings within range.
    logic        cfg_ok;         // Whole configuration usable.
    logic [AW:0] post_smp;       // Post-trigger samples to take.

    assign cap      = cap_of(i_cfg.rate);
    assign pre_ok   = (i_cfg.pre_cycles != 7'h00) && (i_cfg.pre_cycles <= cap);
    assign post_cyc = pre_ok ? 7'(cap - i_cfg.pre_cycles) : 7'h00;
    // A pre count equal to the capacity leaves no post cycle; the record
    // then freezes on the trigger itself and holds only history.
    assign thr_ok   = (i_cfg.nominal >= `SSW_NOM_MIN) && (i_cfg.nominal <= `SSW_NOM_MAX)
                   && (i_cfg.sag_pct >= `SSW_SAG_MIN) && (i_cfg.sag_pct <= `SSW_SAG_MAX)
                   && (i_cfg.swell_pct >= `SSW_SWELL_MIN)
                   && (i_cfg.swell_pct <= `SSW_SWELL_MAX)
                   && (i_cfg.hyst_pct >= `SSW_HYST_MIN)
                   && (i_cfg.hyst_pct <= `SSW_HYST_MAX);
    assign cfg_ok   = pre_ok && thr_ok;
    // Post samples are post cycles times samples per cycle, a left shift;
    // at the default depth the largest case, 63 cycles at 16, still fits.
    assign post_smp = (AW+1)'({7'h00, post_cyc} << spc_shift(i_cfg.rate));

    // ======================================================================
    // Sag and swell detection with hysteresis.
    // ======================================================================
    // Compare in percent-scaled form: rms*100 against nominal*limit.
    logic [27:0] rms_x100;      // Measured magnitude times one hundred.
    logic [28:0] sag_on_lvl;    // Sag start level.
    logic [28:0] sag_off_lvl;   // Sag end level.
    logic [28:0] swl_on_lvl;    // Swell start level.
    logic [28:0] swl_off_lvl;   // Swell end level.
    logic        sag_act;       // Sag in progress.
    logic        swl_act;       // Swell in progress.
    logic        pq_trig;       // One-cycle start of either event.

    assign rms_x100    = 28'(i_rms_volts * 7'd100);
    assign sag_on_lvl  = 29'(i_cfg.nominal * i_cfg.sag_pct);
    assign sag_off_lvl = 29'(i_cfg.nominal * 9'(i_cfg.sag_pct + i_cfg.hyst_pct));
    assign swl_on_lvl  = 29'(i_cfg.nominal * i_cfg.swell_pct);
    assign swl_off_lvl = 29'(i_cfg.nominal * 9'(i_cfg.swell_pct - i_cfg.hyst_pct));

    // Event flags update on each new magnitude; cleared when detection is off.
    always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
        if (!i_rst_n) begin
            sag_act <= 1'b0;
            swl_act <= 1'b0;
        end else if (!(i_cfg.enable && cfg_ok)) begin
            sag_act <= 1'b0;
            swl_act <= 1'b0;
        end else if (i_rms_valid) begin
            if (!sag_act && ({1'b0, rms_x100} < sag_on_lvl)) begin
                sag_act <= 1'b1;
            end else if (sag_act && ({1'b0, rms_x100} >= sag_off_lvl)) begin
                sag_act <= 1'b0;
            end
            if (!swl_act && ({1'b0, rms_x100} > swl_on_lvl)) begin
                swl_act <= 1'b1;
            end else if (swl_act && ({1'b0, rms_x100} <= swl_off_lvl)) begin
                swl_act <= 1'b0;
            end
        end
    end

    // A new event is a rising detection computed from the same inputs.
    assign pq_trig = i_cfg.enable && cfg_ok && i_rms_valid &&
                     ((!sag_act && ({1'b0, rms_x100} < sag_on_lvl)) ||
                      (!swl_act && ({1'b0, rms_x100} > swl_on_lvl)));

    // ======================================================================
    // Circular record buffer and capture sequencer.
    // ======================================================================
    logic [SW-1:0] mem [NS];     // Record storage, one power-cycle window set.
    logic [AW-1:0] wr_ptr;       // Next write slot.
    logic [AW:0]   fill;         // Samples written since arming, saturating.
    logic [AW:0]   post_left;    // Post-trigger samples still to take.
    ssw_state_e    state;        // Sequencer state.
    logic          trig_any;     // Trigger from either source.
    logic          wr_go;        // A sample is stored this cycle.

    assign trig_any = i_manual_trig || pq_trig;
    assign wr_go    = i_smp_valid && ((state == SSW_ARM) || (state == SSW_POST));

    // Sequencer: arm, wait for a trigger, take the post samples, freeze.
    always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
        if (!i_rst_n) begin
            state     <= SSW_IDLE;
            post_left <= '0;
        end else if (!(i_cfg.enable && cfg_ok)) begin
            state     <= SSW_IDLE;
            post_left <= '0;
        end else begin
            case (state)
                SSW_IDLE: begin
                    // One idle cycle clears the fill level before arming.
                    state <= SSW_ARM;
                end
                SSW_ARM: begin
                    // Trigger honoured only once the pre window is filled.
                    if (trig_any && (fill >= (AW+1)'(NS) - post_smp)) begin
                        if (post_smp == '0) begin
                            // No post part: the record is complete at once.
                            state <= SSW_DONE;
                        end else begin
                            state <= SSW_POST;
                        end
                        post_left <= post_smp;
                    end
                end
                SSW_POST: begin
                    // Only stored samples count toward the post part.
                    if (wr_go) begin
                        if (post_left == (AW+1)'(1)) begin
                            state <= SSW_DONE;
                        end
                        post_left <= post_left - (AW+1)'(1);
                    end
                end
                SSW_DONE: begin
                    // The frozen record waits for the exporter to release it.
                    if (i_rec_ack) begin
                        state <= SSW_IDLE;
                    end
                end
                default: begin
                    state <= SSW_IDLE;
                end
            endcase
        end
    end

    // Write pointer and fill level; storage keeps running before a trigger.
    // The pointer is never rewound: readout is relative to it, so where a
    // record starts in storage does not matter.
    always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
        if (!i_rst_n) begin
            wr_ptr <= '0;
            fill   <= '0;
        end else if (state == SSW_IDLE) begin
            fill <= '0;
        end else if (wr_go) begin
            wr_ptr <= AW'(wr_ptr + AW'(1));
            if (fill != (AW+1)'(NS)) begin
                fill <= fill + (AW+1)'(1);
            end
        end
    end

    // Sample storage has no reset so it can map onto block memory.
    always_ff @(posedge i_clk_sys) begin
        if (wr_go) begin
            mem[wr_ptr] <= i_smp_data;
        end
    end

    // Readout is oldest-first: index 0 is the first pre-trigger sample.
    logic [AW-1:0] rd_slot;      // Physical slot for the requested index.
    assign rd_slot = AW'(wr_ptr + i_rd_idx);

    always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_rd_data <= '0;
        end else if (i_rd_en && (state == SSW_DONE)) begin
            o_rd_data <= mem[rd_slot];
        end
    end

    // ======================================================================
    // Status outputs.
    // ======================================================================
    assign o_rec_done          = (state == SSW_DONE);
    assign o_stat.sag_active   = sag_act;
    assign o_stat.swell_active = swl_act;
    assign o_stat.cfg_valid    = cfg_ok;
    assign o_stat.capturing    = (state == SSW_POST);
    assign o_stat.record_ready = (state == SSW_DONE);
    assign o_stat.post_cycles  = post_cyc;

    // ======================================================================
    // Checks.
    // ======================================================================
    // Configuration is static while enabled, so the properties read it
    // directly; every check is off while reset is held.
    AST_NO_CAPTURE_OFF: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
        !i_cfg.enable |=> (state == SSW_IDLE))
        else $error("capture active while disabled");
    AST_SUM_CAP: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
        pre_ok |-> (7'(post_cyc + i_cfg.pre_cycles) == cap))
        else $error("pre plus post differs from capacity");
    AST_PRE_RANGE: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
        (i_cfg.pre_cycles == 7'h00 || i_cfg.pre_cycles > cap) |-> !cfg_ok)
        else $error("out of range pre cycles accepted");
    AST_POST_DERIVED: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
        (pre_ok && i_cfg.rate == `SSW_RATE_128) |-> (post_smp == (AW+1)'(post_cyc * 128)))
        else $error("post sample count wrong");
    AST_TRIG_POST: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
        (state == SSW_ARM && trig_any && i_cfg.enable && cfg_ok
         && fill >= (AW+1)'(NS) - post_smp) |=> (post_left == $past(post_smp)
         && state == (($past(post_smp) == '0) ? SSW_DONE : SSW_POST)))
        else $error("trigger did not start post capture");
    AST_SAG_START: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
        (i_cfg.enable && cfg_ok && i_rms_valid && !sag_act
         && {1'b0, rms_x100} < sag_on_lvl) |=> sag_act)
        else $error("sag not detected");
    AST_SAG_HOLD: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
        (sag_act && i_cfg.enable && cfg_ok && i_rms_valid
         && {1'b0, rms_x100} < sag_off_lvl) |=> sag_act)
        else $error("sag ended before hysteresis level");
    AST_SWELL_HOLD: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
        (swl_act && i_cfg.enable && cfg_ok && i_rms_valid
         && {1'b0, rms_x100} > swl_off_lvl) |=> swl_act)
        else $error("swell ended before hysteresis level");
    AST_MANUAL: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
        (state == SSW_ARM && i_manual_trig && i_cfg.enable && cfg_ok
         && fill >= (AW+1)'(NS) - post_smp)
        |=> (state == SSW_POST || state == SSW_DONE))
        else $error("manual trigger ignored");
    AST_WRAP: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
        (wr_go && state != SSW_IDLE) |=> (wr_ptr == AW'($past(wr_ptr) + AW'(1))))
        else $error("write pointer did not advance");
    // A post phase with nothing left to take would wrap the count and run for 2048 more stored samples.
    AST_POST_LEFT: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
        (state == SSW_POST) |-> (post_left != '0))
        else $error("post phase entered with no samples to take");

    COV_SAG: cover property (@(posedge i_clk_sys) disable iff (!i_rst_n) $rose(sag_act));
    COV_SWELL: cover property (@(posedge i_clk_sys) disable iff (!i_rst_n) $rose(swl_act));
    COV_DONE: cover property (@(posedge i_clk_sys) disable iff (!i_rst_n)
        $rose(state == SSW_DONE));
    COV_MANUAL: cover property (@(posedge i_clk_sys) disable iff (!i_rst_n)
        state == SSW_ARM && i_manual_trig ##1 state == SSW_POST);
    // An early trigger, refused because the history is not yet full.
    COV_EARLY: cover property (@(posedge i_clk_sys) disable iff (!i_rst_n)
        state == SSW_ARM && trig_any && fill < (AW+1)'(NS) - post_smp);
endmodule

// ---- rtl/ssw_defs.svh ----
`ifndef SSW_DEFS_SVH
`define SSW_DEFS_SVH

// ==========================================================================
// Rate codes, limits and capacities.
// ==========================================================================
// Rate select codes: 128, 64, 32 and 16 samples per cycle.
`define SSW_RATE_128      2'h0
`define SSW_RATE_64       2'h1
`define SSW_RATE_32       2'h2
`define SSW_RATE_16       2'h3
// Record capacity in cycles for each rate.
`define SSW_CAP_128       7'h08
`define SSW_CAP_64        7'h10
`define SSW_CAP_32        7'h20
`define SSW_CAP_16        7'h40
// Every record holds this many samples whatever the rate (8 x 128).
`define SSW_REC_SAMPLES   1024
// Settings ranges.
`define SSW_NOM_MIN       21'h000064
`define SSW_NOM_MAX       21'h0f4240
`define SSW_SAG_MIN       8'h01
`define SSW_SAG_MAX       8'h63
`define SSW_SWELL_MIN     8'h65
`define SSW_SWELL_MAX     8'hc7
`define SSW_HYST_MIN      8'h01
`define SSW_HYST_MAX      8'h64
`define SSW_PCT_FULL      8'h64

`endif

// ---- rtl/ssw_pkg.sv ----
package ssw_pkg;
    // Capture sequencer states.
    typedef enum logic [1:0] {
        SSW_IDLE,
        SSW_ARM,
        SSW_POST,
        SSW_DONE
    } ssw_state_e;

    // Configuration bundle presented by the host processor.
    typedef struct packed {
        logic        enable;
        logic [1:0]  rate;
        logic [6:0]  pre_cycles;
        logic [20:0] nominal;
        logic [7:0]  sag_pct;
        logic [7:0]  swell_pct;
        logic [7:0]  hyst_pct;
    } ssw_cfg_s;

    // Status bundle returned to the host processor.
    typedef struct packed {
        logic        sag_active;
        logic        swell_active;
        logic        cfg_valid;
        logic        capturing;
        logic        record_ready;
        logic [6:0]  post_cycles;
    } ssw_stat_s;
endpackage

// ---- verification/ssw_capture_test.sv ----
`timescale 1ns/1ns
// ==========================================================================
// Self-checking bench: a queue model of the record and integer flag models.
// ==========================================================================
module ssw_capture_test;
    import ssw_pkg::*;
    logic        i_clk_sys;  // System clock, 100 ns period.
    logic        i_rst_n;    // Active low reset.
    ssw_cfg_s    cfg;        // Configuration under test.
    ssw_cfg_s    base;       // Known good configuration.
    logic        trig;       // Manual trigger.
    logic        smp_v;      // Sample strobe.
    logic [15:0] smp_d;      // Sample value.
    logic        rms_v;      // Magnitude strobe.
    logic [20:0] rms_d;      // Magnitude in volts.
    logic        rd_en;      // Readout request.
    logic [9:0]  rd_idx;     // Readout index.
    logic [15:0] rd_data;    // Readout data.
    logic        rec_done;   // Record frozen.
    logic        ack;        // Record release.
    ssw_stat_s   stat;       // Status bundle.
    int          error_cnt;  // Mismatches seen.
    int          n_checks;   // Comparisons made.
    int          seed;       // Random seed.
    int          m_sag;      // Model sag flag.
    int          m_swell;    // Model swell flag.
    logic [15:0] q[$];       // Model of the samples accepted for this record.

    ssw_capture #(.SW(16), .NS(1024)) ssw_capture_inst (
        .i_clk_sys(i_clk_sys), .i_rst_n(i_rst_n), .i_cfg(cfg), .i_manual_trig(trig),
        .i_smp_valid(smp_v), .i_smp_data(smp_d), .i_rms_valid(rms_v),
        .i_rms_volts(rms_d), .i_rd_en(rd_en), .i_rd_idx(rd_idx), .o_rd_data(rd_data),
        .o_rec_done(rec_done), .i_rec_ack(ack), .o_stat(stat));

    // Free running clock.
    initial begin
        i_clk_sys = 1'b0;
        forever #50 i_clk_sys = ~i_clk_sys;
    end

    // ======================================================================
    // Shared tasks.
    // ======================================================================
    // Inputs always move 10 ns after the edge, so no race with the design.
    task step;
        @(posedge i_clk_sys);
        #10;
    endtask

    // One comparison; four-state compare so an unknown never matches a known value.
    task chk(input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            error_cnt++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    // Single exit point of the run.
    task report_and_stop;
        if (error_cnt == 0 && n_checks > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    // Bounded wait on capturing (sel 0) or record done (sel 1).
    task wait_for(input int sel, input int lim);
        int k;
        k = 0;
        while ((sel == 0 ? stat.capturing : rec_done) !== 1'b1) begin
            if (k == lim) begin
                chk(1'b0, 1'b1);
                report_and_stop();
            end
            step();
            k++;
        end
    endtask

    // Feed n random samples back to back and keep them in the model.
    task push(input int n);
        repeat (n) begin
            smp_v = 1'b1;
            smp_d = 16'($random(seed));
            q.push_back(smp_d);
            step();
        end
        smp_v = 1'b0;
    endtask

    // Present one magnitude, update the hysteresis model, compare flags.
    task rms(input int v);
        int n;
        n = int'(cfg.nominal);
        rms_v = 1'b1;
        rms_d = v[20:0];
        step();
        rms_v = 1'b0;
        if (m_sag == 0 && v * 100 < n * cfg.sag_pct) begin
            m_sag = 1;
        end else if (m_sag == 1 && v * 100 >= n * (cfg.sag_pct + cfg.hyst_pct)) begin
            m_sag = 0;
        end
        if (m_swell == 0 && v * 100 > n * cfg.swell_pct) begin
            m_swell = 1;
        end else if (m_swell == 1 && v * 100 <= n * (cfg.swell_pct - cfg.hyst_pct)) begin
            m_swell = 0;
        end
        step();
        chk(stat.sag_active, m_sag);
        chk(stat.swell_active, m_swell);
    endtask

    // Vary one field of the good setting, or pre at rate 16 for the default case, and compare the validity flag.
    task cfgv(input int f, input int v, input logic e);
        cfg = base;
        case (f)
            0: cfg.pre_cycles = v[6:0];
            1: cfg.nominal = v[20:0];
            2: cfg.sag_pct = v[7:0];
            3: cfg.swell_pct = v[7:0];
            4: cfg.hyst_pct = v[7:0];
            default: begin
                cfg.rate = 2'h3;
                cfg.pre_cycles = v[6:0];
            end
        endcase
        step();
        chk(stat.cfg_valid, e);
    endtask

    // Full record: early trigger refused, trigger, post part, readout, release.
    task capture(input int r, input int kind);
        int pre;
        int ps;
        pre = 1 + ($unsigned($random(seed)) % ((8 << r) - 1));
        ps = 1024 - pre * (128 >> r);
        cfg.enable = 1'b0;
        step();
        cfg.rate = r[1:0];
        cfg.pre_cycles = pre[6:0];
        cfg.enable = 1'b1;
        step();
        step();
        chk(stat.post_cycles, (8 << r) - pre);
        q.delete();
        push(1023 - ps);
        trig = 1'b1;
        step();
        trig = 1'b0;
        step();
        chk(stat.capturing, 1'b0);
        push(1);
        if (kind == 0) begin
            trig = 1'b1;
            step();
            trig = 1'b0;
        end else begin
            rms(kind == 1 ? 899 : 1101);
        end
        wait_for(0, 3);
        push(ps - 1);
        chk(rec_done, 1'b0);
        push(1);
        wait_for(1, 3);
        chk(stat.record_ready, 1'b1);
        for (int i = 0; i < 1024; i++) begin
            rd_en = 1'b1;
            rd_idx = i[9:0];
            step();
            chk(rd_data, q[i]);
        end
        rd_en = 1'b0;
        ack = 1'b1;
        step();
        ack = 1'b0;
        rms(1000);
        chk(rec_done, 1'b0);
    endtask

    // ======================================================================
    // Main sequence.
    // ======================================================================
    initial begin
        error_cnt = 0;
        n_checks = 0;
        seed = 26;
        m_sag = 0;
        m_swell = 0;
        base = '{1'b1, 2'h0, 7'h04, 21'h0003e8, 8'h5a, 8'h6e, 8'h05};
        cfg = base;
        i_rst_n = 1'b0;
        {trig, smp_v, smp_d, rms_v, rms_d, rd_en, rd_idx, ack} = '0;
        repeat (8) @(posedge i_clk_sys);
        #10;
        i_rst_n = 1'b1;
        chk(rec_done, 1'b0);
        // Boundaries of every setting range, both sides for the pre upper, nominal, sag and hyst lower and swell upper limits.
        cfgv(0, 0, 1'b0);
        cfgv(0, 8, 1'b1);
        cfgv(0, 9, 1'b0);
        cfgv(0, 7, 1'b1);
        cfgv(5, 63, 1'b1);
        cfgv(5, 64, 1'b1);
        cfgv(5, 65, 1'b0);
        cfgv(1, 99, 1'b0);
        cfgv(1, 100, 1'b1);
        cfgv(1, 1000000, 1'b1);
        cfgv(1, 1000001, 1'b0);
        cfgv(2, 0, 1'b0);
        cfgv(2, 1, 1'b1);
        cfgv(2, 95, 1'b1);
        cfgv(2, 100, 1'b0);
        cfgv(3, 105, 1'b1);
        cfgv(3, 100, 1'b0);
        cfgv(3, 199, 1'b1);
        cfgv(3, 200, 1'b0);
        cfgv(4, 0, 1'b0);
        cfgv(4, 1, 1'b1);
        cfgv(4, 101, 1'b0);
        cfg = base;
        step();
        // Start and end thresholds, one volt either side of each.
        rms(900);
        rms(899);
        rms(949);
        rms(950);
        rms(1100);
        rms(1101);
        rms(1051);
        rms(1050);
        // With capture off, history and trigger are ignored.
        cfg.enable = 1'b0;
        step();
        push(1100);
        trig = 1'b1;
        step();
        trig = 1'b0;
        step();
        chk(stat.capturing, 1'b0);
        chk(rec_done, 1'b0);
        // Every rate once; manual, swell and sag triggers.
        for (int r = 0; r < 4; r++) begin
            capture(r, r < 2 ? 0 : r - 1);
        end
        report_and_stop();
    end
endmodule
